// file: pkg/regen_pkg.sv
// Constants for the regeneration avoidance controller: register map,
// field limits, reset values and control-loop timing.
// Assumes a 25 MHz clock and a 32-bit AHB-Lite register bus.
package regen_pkg;

   // Clock and control-loop timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int CTRL_PERIOD_NS = 100000;
   localparam int CTRL_CYCLES    = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W         = 12;

   // Data widths: volts, 0.01 Hz units, percent
   localparam int VBUS_W = 10;
   localparam int FREQ_W = 16;
   localparam int GAIN_W = 8;
   localparam int PROD_W = VBUS_W + 2 * GAIN_W;
   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_THR    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_LIMIT  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_VGAIN  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_FGAIN  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_EXT    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MAXF   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_FREQ   = 8'h20;

   // Function-select codes
   localparam logic [1:0] SEL_OFF    = 2'h0;
   localparam logic [1:0] SEL_ALWAYS = 2'h1;
   localparam logic [1:0] SEL_CONST  = 2'h2;
   localparam logic [1:0] SEL_BAD    = 2'h3;

   // Threshold in volts: 300..800, reset 400 or 780
   localparam logic [VBUS_W-1:0] THR_MIN      = 10'h12C;
   localparam logic [VBUS_W-1:0] THR_MAX      = 10'h320;
   localparam logic [VBUS_W-1:0] THR_RST_LOW  = 10'h190;
   localparam logic [VBUS_W-1:0] THR_RST_HIGH = 10'h30C;

   // Compensation limit in 0.01 Hz: 0..30 Hz, reset 6 Hz, 9999 = off
   localparam logic [FREQ_W-1:0] LIM_MAX = 16'h0BB8;
   localparam logic [FREQ_W-1:0] LIM_OFF = 16'h270F;
   localparam logic [FREQ_W-1:0] LIM_RST = 16'h0258;

   // Gains in percent: 0..200, reset 100
   localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hC8;
   localparam logic [GAIN_W-1:0] GAIN_RST = 8'h64;
   localparam logic [PROD_W-1:0] GAIN_DIV = 26'h0002710;

   // Frequencies in 0.01 Hz
   localparam logic [FREQ_W-1:0] MAXF_RST    = 16'h1770;
   localparam logic [FREQ_W-1:0] PM_MIN_FREQ = 16'h028A;
   localparam logic [FREQ_W-1:0] DECAY_STEP  = 16'h000A;
   localparam logic [7:0]        EXT_RST     = 8'h00;

   // Status register bit positions
   localparam int ST_ACTIVE = 0;
   localparam int ST_HOLD   = 1;
   localparam int ST_LOCKED = 2;

endpackage

// file: pkg/regen_core_if.sv
// Interface between the controller and its increment integrator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface regen_core_if;
   import regen_pkg::*;

   logic [VBUS_W-1:0] excess;
   logic [GAIN_W-1:0] vgain;
   logic [GAIN_W-1:0] fgain;
   logic              trigger;
   logic              clear;
   logic              tick;
   logic [FREQ_W-1:0] inc;

   modport ctl  (output excess, vgain, fgain, trigger, clear, tick,
                 input inc);
   modport core (input excess, vgain, fgain, trigger, clear, tick,
                 output inc);
endinterface

// file: design/regen_increment.sv
// Frequency increment integrator of the regeneration avoidance block.
// Assumes tick, trigger and clear come from logic on the same clock.
`timescale 1ns/1ps
module regen_increment (
   input  wire logic   clock,
   input  wire logic   srst,
   input  wire logic   clk_en,
   regen_core_if.core  link
);
   import regen_pkg::*;

   logic [PROD_W-1:0] prod;
   logic [FREQ_W-1:0] step;
   logic [FREQ_W:0]   sum;
   logic [FREQ_W-1:0] inc_reg;
   logic [FREQ_W-1:0] inc_next;

   // Excess scaled by voltage gain, then by frequency gain
   assign prod = PROD_W'(link.excess) * PROD_W'(link.vgain)
                 * PROD_W'(link.fgain);
   assign step = FREQ_W'(prod / GAIN_DIV);
   assign sum  = {1'b0, inc_reg} + {1'b0, step};
   assign link.inc = inc_reg;

   // Integrate while over threshold, ramp down once the excess is gone
   always_comb
   begin
      inc_next = inc_reg;
      if (link.clear)
         inc_next = '0;
      else if (link.tick)
      begin
         if (link.trigger)
            inc_next = sum[FREQ_W] ? 16'hFFFF : sum[FREQ_W-1:0];
         else if (inc_reg > DECAY_STEP)
            inc_next = inc_reg - DECAY_STEP;
         else
            inc_next = '0;
      end
   end

   // Increment state
   always_ff @(posedge clock)
   begin
      if (srst)
         inc_reg <= '0;
      else if (clk_en)
         inc_reg <= inc_next;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   AST_INC_CLEAR: assert property (
      clk_en && link.clear |=> inc_reg == '0)
      else $error("increment not cleared");
   AST_INC_DECAY: assert property (
      clk_en && link.tick && !link.trigger && !link.clear && inc_reg != '0
      |=> inc_reg < $past(inc_reg))
      else $error("increment did not decay");
   AST_INC_RISE: assert property (
      clk_en && link.tick && link.trigger && !link.clear && step != '0
      && inc_reg != 16'hFFFF |=> inc_reg > $past(inc_reg))
      else $error("increment did not rise");
endmodule

// file: design/regen_avoidance_control.sv
// Regeneration avoidance controller with an AHB-Lite register slave.
// Assumes bus voltage, frequencies and run state come from logic on
// the same clock; clk_en low freezes all state and stalls the bus.
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
// Function
// - Select 0 off, 1 always on, 2 only at constant speed.
// - Threshold 300..800 V, reset 400 V or 780 V by voltage class.
// - Raise frequency when enabled and bus voltage reaches threshold.
// - Compensation limit 0..30 Hz, reset 6 Hz; 9999 removes limit.
// - Accelerating or steady: output at most start frequency plus limit.
// - Decelerating past limit: hold limit until output falls to half.
// - Raised frequency never exceeds the maximum output frequency.
// - Voltage gain 0..200 percent, reset 100, stronger reaction.
// - Separate frequency gain 0..200 percent scales the compensation.
// - Permanent-magnet motor: no action at command 6.5 Hz or lower.
// - While acting, show overvoltage stall and raise stall alarm.
// - While acting, also activate stall prevention.
// - Settings writable only while extended display select is 0.
module regen_avoidance_control #(
   parameter bit HIGH_CLASS = 1'b0
) (
   input  wire logic                          clock,
   input  wire logic                          srst,
   input  wire logic                          clk_en,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic [31:0]                        hrdata,
   input  wire logic [regen_pkg::VBUS_W-1:0]  bus_voltage,
   input  wire logic [regen_pkg::FREQ_W-1:0]  freq_before,
   input  wire logic                          accel,
   input  wire logic                          decel,
   input  wire logic                          const_speed,
   input  wire logic                          pm_motor_mode,
   input  wire logic [regen_pkg::FREQ_W-1:0]  freq_command,
   output logic [regen_pkg::FREQ_W-1:0]       freq_out,
   output logic                               regen_active,
   output logic                               ov_stall_indicate,
   output logic                               stall_alarm_out,
   output logic                               stall_prevent_act
);
   import regen_pkg::*;

   localparam logic [VBUS_W-1:0] THR_RST =
      HIGH_CLASS ? THR_RST_HIGH : THR_RST_LOW;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CTRL_CYCLES - 1);

   regen_core_if link ();

   // Settings
   logic [1:0]        sel_reg;
   logic [VBUS_W-1:0] thr_reg;
   logic [FREQ_W-1:0] lim_reg;
   logic [GAIN_W-1:0] vgain_reg;
   logic [GAIN_W-1:0] fgain_reg;
   logic [7:0]        ext_reg;
   logic [FREQ_W-1:0] max_reg;

   // Bus state
   logic              wr_pend_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [31:0]       hrdata_reg;
   logic [31:0]       rd_data;

   // Control state
   logic [TICK_W-1:0] tick_cnt_reg;
   logic              active_reg;
   logic              hold_reg;
   logic [FREQ_W-1:0] base_reg;
   logic [FREQ_W-1:0] freq_reg;

   // Decode of the bus address phase and write data phase
   wire               addr_ok   = hsel & hready & htrans[1];
   wire               wen       = clk_en & wr_pend_reg;
   wire               unlocked  = (ext_reg == EXT_RST);
   wire               wen_cfg   = wen & unlocked;
   wire               wr_sel    = wen_cfg & (wr_addr_reg == OFS_SELECT);
   wire               wr_thr    = wen_cfg & (wr_addr_reg == OFS_THR);
   wire               wr_lim    = wen_cfg & (wr_addr_reg == OFS_LIMIT);
   wire               wr_vgain  = wen_cfg & (wr_addr_reg == OFS_VGAIN);
   wire               wr_fgain  = wen_cfg & (wr_addr_reg == OFS_FGAIN);
   wire               wr_maxf   = wen_cfg & (wr_addr_reg == OFS_MAXF);
   wire               wr_ext    = wen & (wr_addr_reg == OFS_EXT);

   // Out-of-range values are dropped so a setting is always legal
   wire               sel_ok    = hwdata[31:2] == '0
                                  && hwdata[1:0] != SEL_BAD;
   wire               thr_ok    = hwdata[31:VBUS_W] == '0
                                  && hwdata[VBUS_W-1:0] >= THR_MIN
                                  && hwdata[VBUS_W-1:0] <= THR_MAX;
   wire               lim_ok    = hwdata[31:FREQ_W] == '0
                                  && (hwdata[FREQ_W-1:0] <= LIM_MAX
                                  || hwdata[FREQ_W-1:0] == LIM_OFF);
   wire               gain_ok   = hwdata[31:GAIN_W] == '0
                                  && hwdata[GAIN_W-1:0] <= GAIN_MAX;
   wire               ext_ok    = hwdata[31:8] == '0;
   wire               maxf_ok   = hwdata[31:FREQ_W] == '0;

   // Bus answers with no wait state, but never while frozen
   assign hreadyout = clk_en;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // Read multiplexer, evaluated during the address phase
   always_comb
   begin
      rd_data = '0;
      case (haddr[ADDR_W-1:0])
         OFS_SELECT: rd_data = {30'h0, sel_reg};
         OFS_THR:    rd_data = {22'h0, thr_reg};
         OFS_LIMIT:  rd_data = {16'h0, lim_reg};
         OFS_VGAIN:  rd_data = {24'h0, vgain_reg};
         OFS_FGAIN:  rd_data = {24'h0, fgain_reg};
         OFS_EXT:    rd_data = {24'h0, ext_reg};
         OFS_MAXF:   rd_data = {16'h0, max_reg};
         OFS_STATUS: rd_data = {29'h0, ~unlocked, hold_reg, active_reg};
         OFS_FREQ:   rd_data = {link.inc, freq_reg};
         default:    rd_data = '0;
      endcase
      if (haddr[31:ADDR_W] != '0)
         rd_data = '0;
   end

   // Bus pipeline: write address held into the data phase
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         hrdata_reg  <= '0;
      end
      else if (clk_en)
      begin
         wr_pend_reg <= addr_ok & hwrite & (haddr[31:ADDR_W] == '0);
         wr_addr_reg <= haddr[ADDR_W-1:0];
         if (addr_ok & ~hwrite)
            hrdata_reg <= rd_data;
      end
   end

   // Mode, threshold and limit settings
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         sel_reg <= SEL_OFF;
         thr_reg <= THR_RST;
         lim_reg <= LIM_RST;
      end
      else
      begin
         if (wr_sel && sel_ok)
            sel_reg <= hwdata[1:0];
         if (wr_thr && thr_ok)
            thr_reg <= hwdata[VBUS_W-1:0];
         if (wr_lim && lim_ok)
            lim_reg <= hwdata[FREQ_W-1:0];
      end
   end

   // Gains, maximum frequency and extended display select
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         vgain_reg <= GAIN_RST;
         fgain_reg <= GAIN_RST;
         max_reg   <= MAXF_RST;
         ext_reg   <= EXT_RST;
      end
      else
      begin
         if (wr_vgain && gain_ok)
            vgain_reg <= hwdata[GAIN_W-1:0];
         if (wr_fgain && gain_ok)
            fgain_reg <= hwdata[GAIN_W-1:0];
         if (wr_maxf && maxf_ok)
            max_reg <= hwdata[FREQ_W-1:0];
         if (wr_ext && ext_ok)
            ext_reg <= hwdata[7:0];
      end
   end

   // Enable decision for the present operating state
   wire sel_en   = (sel_reg == SEL_ALWAYS)
                   | ((sel_reg == SEL_CONST) & const_speed);
   wire pm_block = pm_motor_mode & (freq_command <= PM_MIN_FREQ);
   wire allowed  = sel_en & ~pm_block;
   wire over     = bus_voltage >= thr_reg;
   wire trigger  = allowed & over;
   wire tick     = (tick_cnt_reg == TICK_LAST);
   wire act_next = allowed & (over | (link.inc != '0));

   // Integrator hookup: excess feeds the gain chain once per tick
   assign link.excess  = over ? bus_voltage - thr_reg : '0;
   assign link.vgain   = vgain_reg;
   assign link.fgain   = fgain_reg;
   assign link.trigger = trigger;
   assign link.clear   = ~allowed;
   assign link.tick    = tick;

   regen_increment u_inc (
      .clock  (clock),
      .srst   (srst),
      .clk_en (clk_en),
      .link   (link)
   );

   // Limit arithmetic, one bit wider so the sums cannot wrap
   wire [FREQ_W:0]   raw      = {1'b0, freq_before} + {1'b0, link.inc};
   wire [FREQ_W-1:0] base_now = active_reg ? base_reg : freq_before;
   wire [FREQ_W:0]   limit    = {1'b0, base_now} + {1'b0, lim_reg};
   wire              lim_on   = (lim_reg != LIM_OFF);
   wire              over_lim = lim_on & (raw > limit);
   wire [FREQ_W:0]   half     = {2'b00, lim_reg[FREQ_W-1:1]};
   wire              hold_nx  = act_next & lim_on & decel
                                & (hold_reg | over_lim)
                                & ({1'b0, freq_before} > half);
   wire [FREQ_W:0]   capped   = (over_lim | hold_nx) ? limit : raw;
   wire [FREQ_W-1:0] clamped  = (capped > {1'b0, max_reg}) ? max_reg
                                : capped[FREQ_W-1:0];
   wire [FREQ_W-1:0] freq_nx  = act_next ? clamped : freq_before;

   // Control tick divider
   always_ff @(posedge clock)
   begin
      if (srst)
         tick_cnt_reg <= '0;
      else if (clk_en)
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
   end

   // Activity, start frequency, hold and output frequency
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         active_reg <= 1'b0;
         hold_reg   <= 1'b0;
         base_reg   <= '0;
         freq_reg   <= '0;
      end
      else if (clk_en)
      begin
         active_reg <= act_next;
         hold_reg   <= hold_nx;
         base_reg   <= base_now;
         freq_reg   <= freq_nx;
      end
   end

   // One flop drives all indications so they never disagree
   assign freq_out          = freq_reg;
   assign regen_active      = active_reg;
   assign ov_stall_indicate = active_reg;
   assign stall_alarm_out   = active_reg;
   assign stall_prevent_act = active_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   AST_SEL_OFF: assert property (
      clk_en && sel_reg == SEL_OFF |=> !regen_active)
      else $error("active while function is off");
   AST_CONST_ONLY: assert property (
      clk_en && sel_reg == SEL_CONST && !const_speed |=> !regen_active)
      else $error("active outside constant speed");
   AST_THR_RANGE: assert property (
      thr_reg >= THR_MIN && thr_reg <= THR_MAX)
      else $error("threshold out of range");
   AST_TRIGGER: assert property (
      clk_en && trigger |=> regen_active)
      else $error("not active at threshold");
   AST_LIMIT: assert property (
      clk_en && act_next && lim_on && !decel
      |=> {1'b0, freq_out} <= $past(limit))
      else $error("compensated frequency over limit");
   AST_HOLD: assert property (
      clk_en && hold_nx && limit <= {1'b0, max_reg}
      |=> freq_out == $past(limit[FREQ_W-1:0]))
      else $error("limit not held in deceleration");
   AST_MAX: assert property (
      clk_en && act_next |=> freq_out <= $past(max_reg))
      else $error("frequency above maximum");
   AST_PM_BLOCK: assert property (
      clk_en && pm_motor_mode && freq_command <= PM_MIN_FREQ
      |=> !regen_active)
      else $error("active in low-speed magnet range");
   AST_ALARM: assert property (
      clk_en && act_next |=> stall_alarm_out && ov_stall_indicate)
      else $error("stall alarm missing");
   AST_STALL_PREV: assert property (
      clk_en && act_next |=> stall_prevent_act)
      else $error("stall prevention not activated");
   AST_LOCK: assert property (
      clk_en && wr_pend_reg && !unlocked && wr_addr_reg == OFS_THR
      |=> $stable(thr_reg))
      else $error("locked setting changed");

   // Settings stay legal whatever software writes
   AST_SEL_LEGAL: assert property (sel_reg != SEL_BAD)
      else $error("illegal select code");
   AST_LIM_RANGE: assert property (
      lim_reg <= LIM_MAX || lim_reg == LIM_OFF)
      else $error("limit out of range");
   AST_GAIN_RANGE: assert property (
      vgain_reg <= GAIN_MAX && fgain_reg <= GAIN_MAX)
      else $error("gain out of range");
   AST_LOCK_ALL: assert property (
      clk_en && wr_pend_reg && !unlocked
      |=> $stable(sel_reg) && $stable(lim_reg) && $stable(max_reg)
          && $stable(vgain_reg) && $stable(fgain_reg))
      else $error("locked setting written");

   // Activity ends once excess and increment are both gone; an idle path passes straight through
   AST_EXCESS_END: assert property (
      clk_en && !over && link.inc == '0 |=> !regen_active)
      else $error("active without excess");
   AST_IDLE_FREQ: assert property (
      clk_en && !act_next |=> freq_out == $past(freq_before))
      else $error("idle frequency altered");
   AST_NO_LIMIT: assert property (
      clk_en && act_next && !lim_on && raw <= {1'b0, max_reg}
      |=> freq_out == $past(raw[FREQ_W-1:0]))
      else $error("unlimited raise cut");
   AST_BASE_KEEP: assert property (
      clk_en && regen_active |=> $stable(base_reg))
      else $error("start frequency moved");
   AST_HOLD_REL: assert property (
      clk_en && {1'b0, freq_before} <= half |=> !hold_reg)
      else $error("hold kept below half limit");
   AST_HOLD_OFF: assert property (
      clk_en && !decel |=> !hold_reg)
      else $error("hold outside deceleration");
   AST_TICK_ONLY: assert property (
      clk_en && !tick && allowed |=> $stable(link.inc))
      else $error("increment moved between ticks");

   COV_TRIGGER: cover property (clk_en && trigger ##1 regen_active);
   COV_HOLD: cover property (hold_reg && decel);
   COV_CONST: cover property (sel_reg == SEL_CONST && regen_active);
   COV_LOCKED: cover property (wr_pend_reg && !unlocked);
   COV_PM: cover property (pm_block && sel_en && over);
endmodule

// file: test/regen_drive_model.sv
// Far-side model: DC bus voltage sensing and output frequency generator.
// Assumes the bench sets the wanted levels; they reach the pins one clock
// later, as a sampled converter would deliver them.
`timescale 1ns/1ps
module regen_drive_model (
   input  wire logic                         clock,
   input  wire logic                         srst,
   input  wire logic [regen_pkg::VBUS_W-1:0] v_req,
   input  wire logic [regen_pkg::FREQ_W-1:0] fb_req,
   input  wire logic [2:0]                   run_req,
   input  wire logic                         pm_req,
   input  wire logic [regen_pkg::FREQ_W-1:0] cmd_req,
   output logic [regen_pkg::VBUS_W-1:0]      bus_voltage,
   output logic [regen_pkg::FREQ_W-1:0]      freq_before,
   output logic                              accel,
   output logic                              decel,
   output logic                              const_speed,
   output logic                              pm_motor_mode,
   output logic [regen_pkg::FREQ_W-1:0]      freq_command
);
   import regen_pkg::*;

   // One clock of sensing lag; reset leaves a stopped, discharged drive
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         bus_voltage <= '0;
         freq_before <= '0;
         {accel, decel, const_speed} <= 3'h0;
         pm_motor_mode <= 1'b0;
         freq_command <= '0;
      end
      else
      begin
         bus_voltage <= v_req;
         freq_before <= fb_req;
         {accel, decel, const_speed} <= run_req;
         pm_motor_mode <= pm_req;
         freq_command <= cmd_req;
      end
   end
endmodule

// file: test/regen_avoidance_control_tb.sv
// Self-checking bench for the regeneration avoidance controller.
// Assumes the far-side model, one AHB-Lite master and clk_en held high.
`timescale 1ns/1ps
module regen_avoidance_control_tb;
   import regen_pkg::*;

   logic              clock = 1'b0;
   logic              srst = 1'b1;
   logic              hsel = 1'b0;
   logic [31:0]       haddr = 32'h0;
   logic [1:0]        htrans = 2'h0;
   logic              hwrite = 1'b0;
   logic [31:0]       hwdata = 32'h0;
   logic              hreadyout;
   logic              hresp;
   logic [31:0]       hrdata;
   logic [VBUS_W-1:0] v_req = '0;
   logic [FREQ_W-1:0] fb_req = '0;
   logic [FREQ_W-1:0] cmd_req = '0;
   logic [2:0]        run_req = 3'h0;
   logic              pm_req = 1'b0;
   logic [VBUS_W-1:0] bus_voltage;
   logic [FREQ_W-1:0] freq_before;
   logic [FREQ_W-1:0] freq_command;
   logic [FREQ_W-1:0] freq_out;
   logic              accel, decel, const_speed, pm_motor_mode;
   logic              regen_active, ov_stall_indicate;
   logic              stall_alarm_out, stall_prevent_act;
   logic [31:0]       r;
   int                error_cnt = 0;
   int                check_count = 0;
   int                exp_reg[7] = '{0, 400, 600, 100, 100, 0, 6000};
   int                vg, fg, ex;

   always #20 clock = ~clock;

   regen_drive_model far (
      .clock(clock), .srst(srst), .v_req(v_req), .fb_req(fb_req),
      .run_req(run_req), .pm_req(pm_req), .cmd_req(cmd_req),
      .bus_voltage(bus_voltage), .freq_before(freq_before),
      .accel(accel), .decel(decel), .const_speed(const_speed),
      .pm_motor_mode(pm_motor_mode), .freq_command(freq_command)
   );

   regen_avoidance_control uut (
      .clock(clock), .srst(srst), .clk_en(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .bus_voltage(bus_voltage),
      .freq_before(freq_before), .accel(accel), .decel(decel),
      .const_speed(const_speed), .pm_motor_mode(pm_motor_mode),
      .freq_command(freq_command), .freq_out(freq_out),
      .regen_active(regen_active), .ov_stall_indicate(ov_stall_indicate),
      .stall_alarm_out(stall_alarm_out),
      .stall_prevent_act(stall_prevent_act)
   );

   // Single word transfer; each phase waits on ready, data taken at end
   task automatic xfer(input int a, input bit w, input int d);
      hsel   <= 1'b1;
      haddr  <= 32'(a);
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= 32'(d);
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // All four indications must move together
   task automatic chk_act(input logic e);
      repeat (3) @(posedge clock);
      chk("flags", {28'h0, {4{e}}}, {28'h0, regen_active,
          ov_stall_indicate, stall_alarm_out, stall_prevent_act});
   endtask

   // Settings model: refused values and locked writes leave old contents
   function automatic bit legal(int i, int v);
      case (i)
         0: return v < 3;
         1: return v >= 300 && v <= 800;
         2: return v <= 3000 || v == 9999;
         3, 4: return v <= 200;
         5: return v < 256;
         default: return v < 65536;
      endcase
   endfunction

   task automatic wr(input int i, input int v);
      xfer(i * 4, 1'b1, v);
      if (legal(i, v) && (i == 5 || exp_reg[5] == 0))
         exp_reg[i] = v;
   endtask

   task automatic rd_all();
      for (int i = 0; i < 7; i++)
      begin
         xfer(i * 4, 1'b0, 0);
         chk("setting", 32'(exp_reg[i]), r);
         chk("resp", 32'h0, {31'h0, hresp});
      end
   endtask

   task automatic drv(input int v, input int run, input int pm,
                      input int cmd);
      v_req   <= VBUS_W'(v);
      fb_req  <= 16'h0BB8;
      run_req <= 3'(run);
      pm_req  <= pm[0];
      cmd_req <= FREQ_W'(cmd);
      @(posedge clock);
   endtask

   // Increment change across exactly one control tick
   task automatic step_chk(input int e);
      logic [15:0] a;
      repeat (3) @(posedge clock);
      xfer(32, 1'b0, 0);
      a = r[31:16];
      repeat (2498) @(posedge clock);
      xfer(32, 1'b0, 0);
      chk("inc step", {16'h0, 16'(e)}, {16'h0, r[31:16] - a});
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run needs well under 60000 cycles
   initial
   begin
      repeat (60000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end

   initial
   begin
      vg = $urandom(20);
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd_all();
      // Random writes hit refused values and the display-select lock
      for (int k = 0; k < 24; k++)
         wr($urandom % 7, ($urandom % 8 == 0) ? 9999 : $urandom % 1100);
      wr(5, 7);
      wr(1, 500);
      xfer(28, 1'b0, 0);
      chk("locked", 32'h1, {31'h0, r[2]});
      wr(5, 0);
      rd_all();
      xfer(36, 1'b0, 0);
      chk("unmapped", 32'h0, r);
      wr(1, 400);
      wr(2, 600);
      wr(3, 100);
      wr(4, 100);
      wr(6, 6000);
      // Every legal select code in accelerating and steady running
      for (int s = 0; s < 3; s++)
         for (int c = 0; c < 2; c++)
         begin
            wr(0, 0);
            wr(0, s);
            drv(401, c ? 1 : 4, 0, 3000);
            chk_act(s == 1 || (s == 2 && c == 1));
         end
      drv(399, 1, 0, 3000);
      wr(0, 0);
      wr(0, 1);
      chk_act(1'b0);
      drv(400, 1, 0, 3000);
      chk_act(1'b1);
      drv(401, 1, 1, 650);
      wr(0, 0);
      wr(0, 1);
      chk_act(1'b0);
      drv(401, 1, 1, 651);
      chk_act(1'b1);
      wr(0, 0);
      wr(0, 1);
      drv(600, 1, 0, 3000);
      repeat (16000) @(posedge clock);
      chk("limited", 32'd3600, {16'h0, freq_out});
      drv(600, 2, 0, 3000);
      repeat (3) @(posedge clock);
      xfer(28, 1'b0, 0);
      chk("status", 32'h3, {30'h0, r[1:0]});
      chk("held", 32'd3600, {16'h0, freq_out});
      wr(6, 3300);
      repeat (3) @(posedge clock);
      chk("max clamp", 32'd3300, {16'h0, freq_out});
      wr(2, 9999);
      wr(6, 6000);
      for (int k = 0; k < 3; k++)
      begin
         vg = $urandom % 201;
         fg = $urandom % 201;
         ex = 1 + $urandom % 100;
         wr(3, vg);
         wr(4, fg);
         drv(400 + ex, 1, 0, 3000);
         step_chk(ex * vg * fg / 10000);
      end
      drv(300, 1, 0, 3000);
      step_chk(-10);
      wr(0, 0);
      chk_act(1'b0);
      wrap_up();
   end
endmodule
